// ===== pkg/qpd_pkg.sv
// Shared constants for the quad potentiometer serial link, device and controller.
package qpd_pkg;
  localparam int CLK_NS         = 50;
  localparam int LINK_CLK_NS    = 160;
  localparam int SCL_QUARTER_NS = 1000;
  localparam int QUARTER_CYC    = (SCL_QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_TIME_MS   = 5;
  localparam int DEV_PROG_CYC   = PROG_TIME_MS * 1000000 / LINK_CLK_NS;
  // The controller waits one extra quarter so the device's timer has surely expired.
  localparam int HOST_WAIT_CYC  = (PROG_TIME_MS * 1000000 + SCL_QUARTER_NS + CLK_NS - 1) / CLK_NS;

  localparam int NUM_POTS  = 4;
  localparam int NUM_SLOTS = 4;
  localparam int WIPER_W   = 6;
  localparam logic [5:0] WIPER_MAX    = 6'h3f;
  localparam logic [5:0] STORED_RESET = 6'h00;

  // Device type code in the upper address nibble; the value is arbitrary.
  localparam logic [3:0] DEV_TYPE = 4'h6;

  localparam logic [3:0] OP_RD_WIPER  = 4'h9;
  localparam logic [3:0] OP_WR_WIPER  = 4'ha;
  localparam logic [3:0] OP_RD_STORED = 4'hb;
  localparam logic [3:0] OP_WR_STORED = 4'hc;
  localparam logic [3:0] OP_RECALL1   = 4'hd;
  localparam logic [3:0] OP_SAVE1     = 4'he;
  localparam logic [3:0] OP_RECALLALL = 4'h1;
  localparam logic [3:0] OP_SAVEALL   = 4'h8;
  localparam logic [3:0] OP_STEP      = 4'h2;

  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_DATA   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [3:0] MAX_STEPS  = 4'h8;
endpackage

// ===== pkg/qpd_link_if.sv
// Two-wire link between controller and device, with wired-AND data line.
`timescale 1ns/1ps
interface qpd_link_if;
  logic scl;
  logic hostSdaOut;
  logic hostSdaOeN;
  logic devSdaOut;
  logic devSdaOeN;
  logic sda;

  // A released line floats high through the pull-up.
  assign sda = (hostSdaOeN | hostSdaOut) & (devSdaOeN | devSdaOut);

  modport host (output scl, hostSdaOut, hostSdaOeN, input sda);
  modport dev  (input scl, sda, output devSdaOut, devSdaOeN);
endinterface

// ===== hdl/qpd_device.sv
// Device end: serial command decoder with wiper and stored-setting registers.
`timescale 1ns/1ps
// Operation
// - wiper read returns six-bit position, top zero
// - wiper write sets selected wiper position
// - stored read returns selected slot value
// - stored write programs selected slot
// - global recall loads slot into all wipers
// - global save copies all wipers to slot
// - single save copies one wiper to slot
// - single recall loads slot into wiper
// - step command moves wiper per clocked bit
// - programming starts only after stop
// - slot bits select slot by binary value
// - high bit steps up, low steps down
// - programming finishes within five milliseconds
// - reset loads every wiper from slot zero
module qpd_device #(
  parameter int         PROG_CYCLES = qpd_pkg::DEV_PROG_CYC,
  parameter logic [5:0] STORED_INIT = qpd_pkg::STORED_RESET
) (
  // Link clock, reset and link
  input  wire logic                                 linkClk,
  input  wire logic                                 rst,
  qpd_link_if.dev                                   link,
  // User side
  input  wire logic [3:0]                           strapAddr,
  output logic [qpd_pkg::NUM_POTS-1:0][5:0]         wiperPos,
  output logic                                      progBusy
);
  import qpd_pkg::*;

  localparam int PW = $clog2(PROG_CYCLES + 1);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_INSTR, ST_DATAW, ST_ACK, ST_DATAR, ST_STEP} qpd_dev_state_e;
  typedef enum logic [1:0] {PEND_NONE, PEND_DATA, PEND_SAVE1, PEND_SAVEALL} qpd_pend_e;

  logic                          sclMeta, sclSync, sclPrev;
  logic                          sdaMeta, sdaSync, sdaPrev;
  logic [3:0]                    strapMeta, strapSync;
  qpd_dev_state_e                state, next_state, afterAck, next_afterAck;
  qpd_pend_e                     pend, next_pend;
  logic [3:0]                    bitCnt, next_bitCnt;
  logic [7:0]                    shift, next_shift;
  logic [3:0]                    op, next_op;
  logic [1:0]                    pot, next_pot, slot, next_slot;
  logic                          stepDir, next_stepDir;
  logic                          sdaDrvN, next_sdaDrvN;
  logic [5:0]                    pendData, next_pendData;
  logic [NUM_POTS-1:0][5:0]      next_wiperPos;
  logic [5:0]                    stored [NUM_POTS][NUM_SLOTS];
  logic [5:0]                    next_stored [NUM_POTS][NUM_SLOTS];
  logic [PW-1:0]                 progCnt, next_progCnt;
  logic                          next_progBusy;
  logic                          bootDone, next_bootDone;
  logic                          sclRise, sclFall, startCond, stopCond, instrOk;

  assign link.devSdaOut  = 1'b0;
  assign link.devSdaOeN  = sdaDrvN;
  assign sclRise   = sclSync & ~sclPrev;
  assign sclFall   = ~sclSync & sclPrev;
  assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
  assign stopCond  = sclSync & sclPrev & ~sdaPrev & sdaSync;

  // Reserved bits of an instruction must be zero, otherwise it is refused.
  always_comb begin
    case (shift[7:4])
      OP_RD_WIPER, OP_WR_WIPER, OP_STEP: instrOk = shift[3:2] == 2'b00;
      OP_RECALLALL, OP_SAVEALL: instrOk = shift[1:0] == 2'b00;
      OP_RD_STORED, OP_WR_STORED, OP_RECALL1, OP_SAVE1: instrOk = 1'b1;
      default: instrOk = 1'b0;
    endcase
  end

  always_comb begin
    next_state    = state;
    next_afterAck = afterAck;
    next_pend     = pend;
    next_bitCnt   = bitCnt;
    next_shift    = shift;
    next_op       = op;
    next_pot      = pot;
    next_slot     = slot;
    next_stepDir  = stepDir;
    next_sdaDrvN  = sdaDrvN;
    next_pendData = pendData;
    next_wiperPos = wiperPos;
    next_stored   = stored;
    next_progCnt  = progCnt;
    next_progBusy = progBusy;
    next_bootDone = 1'b1;
    if (!bootDone) begin
      for (int p = 0; p < NUM_POTS; p++) begin
        next_wiperPos[p] = stored[p][0];
      end
    end
    if (progBusy) begin
      if (progCnt == PW'(PROG_CYCLES - 1)) begin
        next_progBusy = 1'b0;
      end else begin
        next_progCnt = progCnt + 1'b1;
      end
    end
    if (stopCond) begin
      next_state   = ST_IDLE;
      next_sdaDrvN = 1'b1;
      next_pend    = PEND_NONE;
      if (pend != PEND_NONE) begin
        next_progBusy = 1'b1;
        next_progCnt  = '0;
      end
      case (pend)
        PEND_DATA:  next_stored[pot][slot] = pendData;
        PEND_SAVE1: next_stored[pot][slot] = wiperPos[pot];
        PEND_SAVEALL: begin
          for (int p = 0; p < NUM_POTS; p++) begin
            next_stored[p][slot] = wiperPos[p];
          end
        end
        default: ;
      endcase
    end else if (startCond) begin
      next_state   = ST_ADDR;
      next_bitCnt  = '0;
      next_sdaDrvN = 1'b1;
      next_pend    = PEND_NONE;
    end else begin
      case (state)
        ST_ADDR, ST_INSTR, ST_DATAW: begin
          if (sclRise) begin
            next_shift  = {shift[6:0], sdaSync};
            next_bitCnt = bitCnt + 1'b1;
          end
          if (sclFall && bitCnt == 4'h8) begin
            next_bitCnt   = '0;
            next_state    = ST_IDLE;
            next_afterAck = ST_IDLE;
            if (state == ST_ADDR) begin
              if (shift == {DEV_TYPE, strapSync} && !progBusy) begin
                next_sdaDrvN  = 1'b0;
                next_state    = ST_ACK;
                next_afterAck = ST_INSTR;
              end
            end else if (state == ST_INSTR) begin
              next_op   = shift[7:4];
              next_slot = shift[3:2];
              next_pot  = shift[1:0];
              if (instrOk) begin
                next_sdaDrvN = 1'b0;
                next_state   = ST_ACK;
                case (shift[7:4])
                  OP_RD_WIPER: begin
                    next_afterAck = ST_DATAR;
                    next_shift    = {2'b00, wiperPos[shift[1:0]]};
                  end
                  OP_RD_STORED: begin
                    next_afterAck = ST_DATAR;
                    next_shift    = {2'b00, stored[shift[1:0]][shift[3:2]]};
                  end
                  OP_WR_WIPER, OP_WR_STORED: next_afterAck = ST_DATAW;
                  OP_RECALL1: next_wiperPos[shift[1:0]] = stored[shift[1:0]][shift[3:2]];
                  OP_RECALLALL: begin
                    for (int p = 0; p < NUM_POTS; p++) begin
                      next_wiperPos[p] = stored[p][shift[3:2]];
                    end
                  end
                  OP_SAVE1:   next_pend = PEND_SAVE1;
                  OP_SAVEALL: next_pend = PEND_SAVEALL;
                  OP_STEP:    next_afterAck = ST_STEP;
                  default: ;
                endcase
              end
            end else begin
              next_sdaDrvN = 1'b0;
              next_state   = ST_ACK;
              if (op == OP_WR_WIPER) begin
                next_wiperPos[pot] = shift[5:0];
              end else begin
                next_pend     = PEND_DATA;
                next_pendData = shift[5:0];
              end
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            next_state   = afterAck;
            next_bitCnt  = '0;
            next_sdaDrvN = (afterAck == ST_DATAR) ? shift[7] : 1'b1;
          end
        end
        ST_DATAR: begin
          if (sclRise) begin
            next_bitCnt = bitCnt + 1'b1;
          end
          if (sclFall) begin
            if (bitCnt == 4'h8) begin
              next_sdaDrvN = 1'b1;
              next_state   = ST_IDLE;
            end else begin
              next_shift   = {shift[6:0], 1'b0};
              next_sdaDrvN = shift[6];
            end
          end
        end
        ST_STEP: begin
          // Applying on the falling edge keeps the stop condition from counting as a step.
          if (sclRise) begin
            next_stepDir = sdaSync;
          end
          if (sclFall) begin
            if (stepDir && wiperPos[pot] != WIPER_MAX) begin
              next_wiperPos[pot] = wiperPos[pot] + 1'b1;
            end else if (!stepDir && wiperPos[pot] != 6'h00) begin
              next_wiperPos[pot] = wiperPos[pot] - 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      sclMeta   <= 1'b1;
      sclSync   <= 1'b1;
      sclPrev   <= 1'b1;
      sdaMeta   <= 1'b1;
      sdaSync   <= 1'b1;
      sdaPrev   <= 1'b1;
      strapMeta <= 4'h0;
      strapSync <= 4'h0;
    end else begin
      sclMeta   <= link.scl;
      sclSync   <= sclMeta;
      sclPrev   <= sclSync;
      sdaMeta   <= link.sda;
      sdaSync   <= sdaMeta;
      sdaPrev   <= sdaSync;
      strapMeta <= strapAddr;
      strapSync <= strapMeta;
    end
  end

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      state    <= ST_IDLE;
      afterAck <= ST_IDLE;
      pend     <= PEND_NONE;
      bitCnt   <= 4'h0;
      shift    <= 8'h00;
      op       <= 4'h0;
      pot      <= 2'h0;
      slot     <= 2'h0;
      stepDir  <= 1'b0;
      sdaDrvN  <= 1'b1;
      pendData <= 6'h00;
      wiperPos <= '0;
      progCnt  <= '0;
      progBusy <= 1'b0;
      bootDone <= 1'b0;
      for (int p = 0; p < NUM_POTS; p++) begin
        for (int s = 0; s < NUM_SLOTS; s++) begin
          stored[p][s] <= STORED_INIT;
        end
      end
    end else begin
      state    <= next_state;
      afterAck <= next_afterAck;
      pend     <= next_pend;
      bitCnt   <= next_bitCnt;
      shift    <= next_shift;
      op       <= next_op;
      pot      <= next_pot;
      slot     <= next_slot;
      stepDir  <= next_stepDir;
      sdaDrvN  <= next_sdaDrvN;
      pendData <= next_pendData;
      wiperPos <= next_wiperPos;
      progCnt  <= next_progCnt;
      progBusy <= next_progBusy;
      bootDone <= next_bootDone;
      stored   <= next_stored;
    end
  end
endmodule

// ===== hdl/qpd_host.sv
// Controller end: APB-programmed master that issues commands on the two-wire link.
`timescale 1ns/1ps
module qpd_host #(
  parameter int QUARTER     = qpd_pkg::QUARTER_CYC,
  parameter int WAIT_CYCLES = qpd_pkg::HOST_WAIT_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link
  qpd_link_if.host         link
);
  import qpd_pkg::*;

  localparam int QW = $clog2(QUARTER + 1);
  localparam int WW = $clog2(WAIT_CYCLES + 1);

  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_WAIT} qpd_host_state_e;

  qpd_host_state_e state, next_state;
  logic [QW-1:0]   qCnt, next_qCnt;
  logic [WW-1:0]   waitCnt, next_waitCnt;
  logic [1:0]      phase, next_phase, byteIdx, next_byteIdx, lastByte;
  logic [3:0]      bitIdx, next_bitIdx, stepCnt, next_stepCnt, cmdAddr, next_cmdAddr;
  logic [7:0]      txShift, next_txShift, rxShift, next_rxShift, rdData, next_rdData;
  logic [7:0]      cmdInstr, next_cmdInstr, wrData, next_wrData;
  logic            scl, next_scl, sdaOeN, next_sdaOeN, nack, next_nack;
  logic [31:0]     next_prdata;
  logic            next_pslverr;
  logic            sdaMeta, sdaSync, tick, apbWr, rdOp, wrOp, stepOp, nvOp, atData, curBit;

  assign link.scl        = scl;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOeN = sdaOeN;
  assign tick   = qCnt == QW'(QUARTER - 1);
  assign apbWr  = psel & penable & pwrite & pready;
  assign rdOp   = cmdInstr[7:4] == OP_RD_WIPER || cmdInstr[7:4] == OP_RD_STORED;
  assign wrOp   = cmdInstr[7:4] == OP_WR_WIPER || cmdInstr[7:4] == OP_WR_STORED;
  assign stepOp = cmdInstr[7:4] == OP_STEP;
  assign nvOp   = cmdInstr[7:4] == OP_WR_STORED || cmdInstr[7:4] == OP_SAVE1 || cmdInstr[7:4] == OP_SAVEALL;
  assign lastByte = (rdOp | wrOp | stepOp) ? 2'd2 : 2'd1;
  assign atData = byteIdx == 2'd2;
  // A one releases the line; ack slots and read data are always released.
  assign curBit = (atData && stepOp) ? wrData[bitIdx[2:0]] :
                  (bitIdx == 4'h8 || (atData && rdOp)) ? 1'b1 : txShift[7];

  always_comb begin
    next_state    = state;
    next_qCnt     = qCnt;
    next_waitCnt  = waitCnt;
    next_phase    = phase;
    next_byteIdx  = byteIdx;
    next_bitIdx   = bitIdx;
    next_stepCnt  = stepCnt;
    next_cmdAddr  = cmdAddr;
    next_txShift  = txShift;
    next_rxShift  = rxShift;
    next_rdData   = rdData;
    next_cmdInstr = cmdInstr;
    next_wrData   = wrData;
    next_scl      = scl;
    next_sdaOeN   = sdaOeN;
    next_nack     = nack;
    next_prdata   = prdata;
    next_pslverr  = pslverr;
    if (state == H_START || state == H_BIT || state == H_STOP) begin
      next_qCnt = tick ? '0 : qCnt + 1'b1;
    end
    if (psel && !penable) begin
      next_pslverr = 1'b0;
      case (paddr)
        REG_CMD:    next_prdata = {20'h00000, cmdAddr, cmdInstr};
        REG_DATA:   next_prdata = {20'h00000, stepCnt, wrData};
        REG_STATUS: next_prdata = {16'h0000, rdData, 6'h00, nack, state != H_IDLE};
        default: begin
          next_prdata  = 32'h00000000;
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (apbWr && paddr == REG_DATA) begin
      next_wrData  = pwdata[7:0];
      next_stepCnt = (pwdata[11:8] > MAX_STEPS) ? MAX_STEPS : pwdata[11:8];
    end
    case (state)
      H_IDLE: begin
        if (apbWr && paddr == REG_CMD) begin
          next_cmdInstr = pwdata[7:0];
          next_cmdAddr  = pwdata[11:8];
          next_txShift  = {DEV_TYPE, pwdata[11:8]};
          next_state    = H_START;
          next_phase    = 2'd0;
          next_qCnt     = '0;
          next_nack     = 1'b0;
          next_byteIdx  = 2'd0;
          next_bitIdx   = 4'h0;
        end
      end
      H_START: begin
        if (tick) begin
          if (phase == 2'd0) begin
            next_sdaOeN = 1'b0;
            next_phase  = 2'd1;
          end else begin
            next_scl   = 1'b0;
            next_state = H_BIT;
            next_phase = 2'd0;
          end
        end
      end
      H_BIT: begin
        if (phase == 2'd0) begin
          next_sdaOeN = curBit;
        end
        if (tick) begin
          next_phase = phase + 1'b1;
          case (phase)
            2'd0: next_scl = 1'b1;
            2'd2: begin
              next_scl = 1'b0;
              if (bitIdx == 4'h8) begin
                next_nack = sdaSync & ~(atData & rdOp);
              end else if (atData && rdOp) begin
                next_rxShift = {rxShift[6:0], sdaSync};
              end else begin
                next_txShift = {txShift[6:0], 1'b0};
              end
            end
            2'd3: begin
              if (nack) begin
                next_state = H_STOP;
              end else if (atData && stepOp) begin
                if (bitIdx + 1'b1 >= stepCnt) begin
                  next_state = H_STOP;
                end else begin
                  next_bitIdx = bitIdx + 1'b1;
                end
              end else if (bitIdx != 4'h8) begin
                next_bitIdx = bitIdx + 1'b1;
              end else if (byteIdx == lastByte) begin
                next_state = H_STOP;
              end else begin
                next_byteIdx = byteIdx + 1'b1;
                next_bitIdx  = 4'h0;
                // A written data byte always leaves with its two top bits clear.
                next_txShift = (byteIdx == 2'd0) ? cmdInstr : {2'b00, wrData[5:0]};
                if (byteIdx == 2'd1 && stepOp && stepCnt == 4'h0) begin
                  next_state = H_STOP;
                end
              end
            end
            default: ;
          endcase
        end
      end
      H_STOP: begin
        if (phase == 2'd0) begin
          next_sdaOeN = 1'b0;
        end
        if (tick) begin
          next_phase = phase + 1'b1;
          case (phase)
            2'd0: next_scl = 1'b1;
            2'd1: next_sdaOeN = 1'b1;
            default: begin
              next_phase   = 2'd0;
              next_waitCnt = '0;
              next_state   = (nvOp && !nack) ? H_WAIT : H_IDLE;
              if (rdOp) begin
                next_rdData = rxShift;
              end
            end
          endcase
        end
      end
      H_WAIT: begin
        if (waitCnt == WW'(WAIT_CYCLES - 1)) begin
          next_state = H_IDLE;
        end else begin
          next_waitCnt = waitCnt + 1'b1;
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdaMeta  <= 1'b1;
      sdaSync  <= 1'b1;
      state    <= H_IDLE;
      qCnt     <= '0;
      waitCnt  <= '0;
      phase    <= 2'd0;
      byteIdx  <= 2'd0;
      bitIdx   <= 4'h0;
      stepCnt  <= 4'h0;
      cmdAddr  <= 4'h0;
      txShift  <= 8'h00;
      rxShift  <= 8'h00;
      rdData   <= 8'h00;
      cmdInstr <= 8'h00;
      wrData   <= 8'h00;
      scl      <= 1'b1;
      sdaOeN   <= 1'b1;
      nack     <= 1'b0;
      prdata   <= 32'h00000000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      sdaMeta  <= link.sda;
      sdaSync  <= sdaMeta;
      state    <= next_state;
      qCnt     <= next_qCnt;
      waitCnt  <= next_waitCnt;
      phase    <= next_phase;
      byteIdx  <= next_byteIdx;
      bitIdx   <= next_bitIdx;
      stepCnt  <= next_stepCnt;
      cmdAddr  <= next_cmdAddr;
      txShift  <= next_txShift;
      rxShift  <= next_rxShift;
      rdData   <= next_rdData;
      cmdInstr <= next_cmdInstr;
      wrData   <= next_wrData;
      scl      <= next_scl;
      sdaOeN   <= next_sdaOeN;
      nack     <= next_nack;
      prdata   <= next_prdata;
      pready   <= 1'b1;
      pslverr  <= next_pslverr;
    end
  end
endmodule

// ===== bench/qpd_link_asserts.sv
// Protocol checks on the two-wire link between controller and device.
`timescale 1ns/1ps
module qpd_link_asserts #(
  parameter int QUARTER = 16
) (
  // Host clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link wires
  input wire logic scl,
  input wire logic hostSdaOut,
  input wire logic hostSdaOeN,
  input wire logic devSdaOut,
  input wire logic devSdaOeN,
  input wire logic sda
);
  localparam int QL = 3 * QUARTER;
  logic [15:0] lowCnt;
  logic [15:0] next_lowCnt;

  always_comb begin
    next_lowCnt = scl ? 16'h0000 : lowCnt + 16'h0001;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowCnt <= 16'h0000;
    end else begin
      lowCnt <= next_lowCnt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence startSeq;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stopSeq;
    scl && $past(scl) && $rose(sda);
  endsequence

  // The first low phase after a start is one quarter, every other one two.
  a_scl_low_time: assert property ($rose(scl) |-> lowCnt == 16'(QUARTER) || lowCnt == 16'(2 * QUARTER))
    else $error("clock low phase has the wrong length");
  a_start_then_clock: assert property (startSeq |-> ##[1:QL] !scl)
    else $error("no clock after start");
  a_stop_then_idle: assert property (stopSeq |-> (scl && sda) [*8])
    else $error("link not idle after stop");
  a_start_by_host: assert property (startSeq |-> devSdaOeN && !hostSdaOeN)
    else $error("start not made by the controller");
  a_stop_dev_free: assert property (stopSeq |-> devSdaOeN && hostSdaOeN)
    else $error("data line not released at stop");
  a_open_drain: assert property (!hostSdaOut && !devSdaOut)
    else $error("data line driven high");
  a_dev_change_low: assert property ($changed(devSdaOeN) |-> !scl)
    else $error("device changed data while clock high");
  a_dev_hold_high: assert property ($rose(scl) && !devSdaOeN |-> (!devSdaOeN) [*8])
    else $error("device released data during clock high");
endmodule

// ===== bench/tb_quad_pot_serial_command_decoder.sv
// Self-checking bench: APB commands through the controller to the device.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_quad_pot_serial_command_decoder;
  import qpd_pkg::*;
  localparam int QT = 16;
  // A non-zero start value makes the power-up recall visible on the wipers.
  localparam logic [5:0] SINIT = 6'h15;
  logic            clk, linkClk, rst, psel, penable, pwrite, pready, pslverr, progBusy, busySeen;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [3:0]      strapAddr;
  logic [3:0][5:0] wiperPos, wexp;
  logic [5:0]      sexp [4][4];
  int              mismatches, num_checks;

  qpd_link_if link ();
  qpd_host #(.QUARTER(QT), .WAIT_CYCLES(100)) qpd_host_inst (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  qpd_device #(.PROG_CYCLES(20), .STORED_INIT(SINIT)) qpd_device_inst (.linkClk(linkClk), .rst(rst), .link(link),
    .strapAddr(strapAddr), .wiperPos(wiperPos), .progBusy(progBusy));
  qpd_link_asserts #(.QUARTER(QT)) qpd_link_asserts_inst (.clk(clk), .rst(rst), .scl(link.scl),
    .hostSdaOut(link.hostSdaOut), .hostSdaOeN(link.hostSdaOeN), .devSdaOut(link.devSdaOut),
    .devSdaOeN(link.devSdaOeN), .sda(link.sda));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Odd start offset keeps the link clock out of phase with the host clock.
  initial begin
    linkClk = 1'b0;
    #37;
    forever #80 linkClk = ~linkClk;
  end

  task summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task cmd(input logic [3:0] op, input logic [1:0] s, input logic [1:0] p, input logic [11:0] d,
           input logic [3:0] adr);
    int n;
    apb(1'b1, REG_DATA, {20'h0, d});
    apb(1'b1, REG_CMD, {20'h0, adr, op, s, p});
    n = 0;
    rd = 32'h1;
    busySeen = 1'b0;
    while (rd[0] !== 1'b0 && n < 3000) begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (progBusy === 1'b1) begin
        busySeen = 1'b1;
      end
      n++;
    end
    `CHK(rd[0], 1'b0)
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strapAddr = 4'h5;
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    wexp = {4{SINIT}};
    foreach (sexp[i, j]) sexp[i][j] = SINIT;
    `CHK(wiperPos, wexp)
    for (int p = 0; p < 4; p++) begin
      wexp[p] = 6'(p * 9 + 5);
      cmd(OP_WR_WIPER, 2'h0, 2'(p), {6'h03, wexp[p]}, 4'h5);
      `CHK(wiperPos, wexp)
      cmd(OP_RD_WIPER, 2'h0, 2'(p), 12'h000, 4'h5);
      `CHK(rd[15:8], {2'h0, wexp[p]})
    end
    for (int s = 0; s < 4; s++) begin
      sexp[1][s] = 6'(s + 40);
      cmd(OP_WR_STORED, 2'(s), 2'h1, {6'h03, sexp[1][s]}, 4'h5);
      `CHK(busySeen, 1'b1)
      cmd(OP_RD_STORED, 2'(s), 2'h1, 12'h000, 4'h5);
      `CHK(busySeen, 1'b0)
      `CHK(rd[15:8], {2'h0, sexp[1][s]})
      `CHK(progBusy, 1'b0)
    end
    cmd(OP_RECALL1, 2'h2, 2'h1, 12'h000, 4'h5);
    wexp[1] = sexp[1][2];
    `CHK(wiperPos, wexp)
    cmd(OP_SAVE1, 2'h3, 2'h0, 12'h000, 4'h5);
    sexp[0][3] = wexp[0];
    cmd(OP_RD_STORED, 2'h3, 2'h0, 12'h000, 4'h5);
    `CHK(rd[15:8], {2'h0, sexp[0][3]})
    cmd(OP_SAVEALL, 2'h1, 2'h0, 12'h000, 4'h5);
    for (int p = 0; p < 4; p++) sexp[p][1] = wexp[p];
    for (int r = 0; r < 2; r++) begin
      cmd(OP_RECALLALL, 2'(r), 2'h0, 12'h000, 4'h5);
      for (int p = 0; p < 4; p++) wexp[p] = sexp[p][r];
      `CHK(wiperPos, wexp)
    end
    // Three up-steps from 62 saturate at the top before five down-steps.
    wexp[2] = 6'h3e;
    cmd(OP_WR_WIPER, 2'h0, 2'h2, 12'h03e, 4'h5);
    cmd(OP_STEP, 2'h0, 2'h2, 12'h807, 4'h5);
    wexp[2] = 6'h3a;
    `CHK(wiperPos, wexp)
    cmd(OP_WR_WIPER, 2'h0, 2'h0, 12'h011, 4'h3);
    `CHK(rd[1], 1'b1)
    `CHK(wiperPos, wexp)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(pslverr, 1'b1)
    summarize();
  end

  initial begin
    #4500000;
    mismatches++;
    summarize();
  end
endmodule
